//--- ssdm_pkg.sv
/*
 * constants, register map and state type of the safe speed and direction monitor.
 * assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
package ssdm_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int MS_CYCLES_DEF  = MS_NS / CLK_PERIOD_NS;
    localparam int DEG_PER_REV    = 360;
    localparam int MS_PER_MIN     = 60000;
    localparam int MDEG_PER_DEG   = 1000;
    localparam int MDEG_PER_RPMMS = DEG_PER_REV * MDEG_PER_DEG / MS_PER_MIN;

    // ****************************************
    // register map
    // ****************************************
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_LIMIT     = 8'h04;
    localparam logic [7:0] OFS_HYST      = 8'h08;
    localparam logic [7:0] OFS_FILT      = 8'h0C;
    localparam logic [7:0] OFS_ACCEPT    = 8'h10;
    localparam logic [7:0] OFS_DELAY     = 8'h14;
    localparam logic [7:0] OFS_TOL       = 8'h18;
    localparam logic [7:0] OFS_RAMP      = 8'h1C;
    localparam logic [7:0] OFS_STATUS    = 8'h20;

    localparam int CTRL_EXT_EN      = 0;
    localparam int CTRL_HYST_EN     = 1;
    localparam int CTRL_DIR_EN      = 2;
    localparam int CTRL_SSM_OFF     = 3;
    localparam int CTRL_DIR_OFF     = 4;
    localparam int CTRL_STOP_RESP   = 5;
    localparam int CTRL_ACCEPT_GO   = 6;

    localparam logic [15:0] LIMIT_RST   = 16'h0014;
    localparam logic [15:0] HYST_RST    = 16'h000A;
    localparam logic [15:0] FILT_RST    = 16'h0000;
    localparam logic [16:0] ACCEPT_RST  = 17'h09C40;
    localparam logic [16:0] ACCEPT_MAX  = 17'h186A0;
    localparam logic [15:0] DELAY_RST   = 16'h0064;
    localparam logic [15:0] TOL_RST     = 16'h000C;
    localparam logic [15:0] RAMP_RST    = 16'h03E8;
    localparam logic        RESP_RST    = 1'b1;

    typedef enum logic [2:0] {
        DIR_IDLE,
        DIR_DELAY,
        DIR_WATCH,
        DIR_BRAKE,
        DIR_TORQUE_OFF
    } ssdm_dir_state_t;
endpackage

//--- ssdm_monitor.sv
/*
 * safe speed monitor, safe direction monitor and acceptance timer behind an APB slave.
 * assumes speed and control inputs synchronous to clk_sys; speed in signed rpm.
 */
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ssdm_monitor #(
    parameter int MS_CYCLES = ssdm_pkg::MS_CYCLES_DEF
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ssdm_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic signed [15:0]            speed_rpm,
    input  wire logic                          motor_on,
    input  wire logic                          select_positive,
    input  wire logic                          select_negative,
    output logic                               below_speed_limit_flag,
    output logic                               positive_direction_active_flag,
    output logic                               negative_direction_active_flag,
    output logic                               direction_violation,
    output logic                               fast_stop_ramp,
    output logic                               torque_off,
    output logic                               speed_limit_active,
    output logic                               acceptance_active,
    output logic      [15:0]                   fast_stop_ramp_time
);
    import ssdm_pkg::*;

    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least one");
    end

    // ****************************************
    // apb slave
    // ****************************************
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        ext_en_reg;
    logic        hyst_en_reg;
    logic        dir_en_reg;
    logic        ssm_off_reg;
    logic        dir_off_reg;
    logic        resp_reg;
    logic [15:0] limit_reg;
    logic [15:0] hyst_reg;
    logic [15:0] filt_time_reg;
    logic [16:0] accept_time_reg;
    logic [15:0] delay_reg;
    logic [15:0] tol_reg;
    logic [15:0] ramp_reg;
    logic        below_reg;
    logic        pos_reg;
    logic        neg_reg;
    logic        viol_reg;
    logic        fstop_reg;
    logic        toff_reg;
    logic        slim_reg;
    logic        acc_act_reg;

    wire         access    = ce && psel && penable;
    wire         commit    = access && pready_reg;
    wire         wr_commit = commit && pwrite;
    wire         hit_ctrl  = (paddr == OFS_CTRL);
    wire         hit_lim   = (paddr == OFS_LIMIT);
    wire         hit_hyst  = (paddr == OFS_HYST);
    wire         hit_filt  = (paddr == OFS_FILT);
    wire         hit_acc   = (paddr == OFS_ACCEPT);
    wire         hit_dly   = (paddr == OFS_DELAY);
    wire         hit_tol   = (paddr == OFS_TOL);
    wire         hit_ramp  = (paddr == OFS_RAMP);
    wire         hit_stat  = (paddr == OFS_STATUS);
    wire         mapped    = hit_ctrl | hit_lim | hit_hyst | hit_filt | hit_acc | hit_dly | hit_tol
                             | hit_ramp | hit_stat;
    wire  [31:0] ctrl_rd   = {26'h0000000, resp_reg, dir_off_reg, ssm_off_reg, dir_en_reg, hyst_en_reg,
                              ext_en_reg};
    wire  [31:0] stat_rd   = {24'h000000, slim_reg, toff_reg, fstop_reg, acc_act_reg, viol_reg, neg_reg,
                              pos_reg, below_reg};
    // durations past the limit are cut, not refused, so a write never fails
    wire  [16:0] acc_wr    = (pwdata[16:0] > ACCEPT_MAX || pwdata[31:17] != 15'h0000) ? ACCEPT_MAX
                             : pwdata[16:0];
    wire  [31:0] rd_mux    = hit_ctrl ? ctrl_rd
                           : hit_lim  ? {16'h0000, limit_reg}
                           : hit_hyst ? {16'h0000, hyst_reg}
                           : hit_filt ? {16'h0000, filt_time_reg}
                           : hit_acc  ? {15'h0000, accept_time_reg}
                           : hit_dly  ? {16'h0000, delay_reg}
                           : hit_tol  ? {16'h0000, tol_reg}
                           : hit_ramp ? {16'h0000, ramp_reg}
                           : hit_stat ? stat_rd : 32'h00000000;
    wire         accept_go = wr_commit && hit_ctrl && pwdata[CTRL_ACCEPT_GO];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (ce) begin
            pready_reg  <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !mapped;
            prdata_reg  <= (access && !pready_reg && !pwrite) ? rd_mux : prdata_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_en_reg      <= 1'b0;
            hyst_en_reg     <= 1'b0;
            dir_en_reg      <= 1'b0;
            ssm_off_reg     <= 1'b0;
            dir_off_reg     <= 1'b0;
            resp_reg        <= RESP_RST;
            limit_reg       <= LIMIT_RST;
            hyst_reg        <= HYST_RST;
            filt_time_reg   <= FILT_RST;
            accept_time_reg <= ACCEPT_RST;
            delay_reg       <= DELAY_RST;
            tol_reg         <= TOL_RST;
            ramp_reg        <= RAMP_RST;
        end else if (wr_commit) begin
            if (hit_ctrl) begin
                ext_en_reg  <= pwdata[CTRL_EXT_EN];
                hyst_en_reg <= pwdata[CTRL_HYST_EN];
                dir_en_reg  <= pwdata[CTRL_DIR_EN];
                ssm_off_reg <= pwdata[CTRL_SSM_OFF];
                dir_off_reg <= pwdata[CTRL_DIR_OFF];
                resp_reg    <= pwdata[CTRL_STOP_RESP];
            end
            if (hit_lim)  limit_reg       <= pwdata[15:0];
            if (hit_hyst) hyst_reg        <= pwdata[15:0];
            if (hit_filt) filt_time_reg   <= pwdata[15:0];
            if (hit_acc)  accept_time_reg <= acc_wr;
            if (hit_dly)  delay_reg       <= pwdata[15:0];
            if (hit_tol)  tol_reg         <= pwdata[15:0];
            if (hit_ramp) ramp_reg        <= pwdata[15:0];
        end
    end

    // ****************************************
    // millisecond time base
    // ****************************************
    logic [31:0] tb_cnt_reg;
    wire         ms_tick = ce && (tb_cnt_reg == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tb_cnt_reg <= 32'h00000000;
        end else if (ce) begin
            tb_cnt_reg <= ms_tick ? 32'h00000000 : tb_cnt_reg + 32'h00000001;
        end
    end

    // ****************************************
    // acceptance timer
    // ****************************************
    logic [16:0] acc_cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_act_reg <= 1'b0;
            acc_cnt_reg <= 17'h00000;
        end else if (accept_go) begin
            acc_act_reg <= (accept_time_reg != 17'h00000);
            acc_cnt_reg <= accept_time_reg;
        end else if (ms_tick && acc_act_reg) begin
            acc_cnt_reg <= acc_cnt_reg - 17'h00001;
            acc_act_reg <= (acc_cnt_reg > 17'h00001);
        end
    end

    // ****************************************
    // safe speed monitor
    // ****************************************
    logic signed [15:0] filt_reg;

    function automatic logic [4:0] filt_shift(input logic [15:0] t);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (t[i]) s = 5'(i + 1);
        end
        return s;
    endfunction

    // first order smoothing, time constant the next power of two above the set time in ms
    wire signed [16:0] filt_diff = 17'(speed_rpm) - 17'(filt_reg);
    wire        [4:0]  fsh       = filt_shift(filt_time_reg);
    wire signed [15:0] filt_step = 16'(filt_diff >>> fsh);
    wire               use_filt  = hyst_en_reg && (fsh != 5'h00);
    wire signed [15:0] spd_eff   = use_filt ? filt_reg : speed_rpm;
    wire        [15:0] spd_abs   = spd_eff[15] ? 16'(-spd_eff) : spd_eff;
    wire               ssm_on    = ext_en_reg && (motor_on || !ssm_off_reg);
    wire        [16:0] lo_thr    = (hyst_reg >= limit_reg) ? 17'h00000 : 17'(limit_reg - hyst_reg);
    wire               below_raw = (spd_abs < limit_reg);
    wire               below_hys = below_reg ? (17'(spd_abs) < 17'(limit_reg))
                                             : (17'(spd_abs) < lo_thr);
    wire               below_nxt = ssm_on && (hyst_en_reg ? below_hys : below_raw);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            filt_reg  <= 16'sh0000;
            below_reg <= 1'b0;
        end else if (ce) begin
            if (!use_filt) filt_reg <= speed_rpm;
            else if (ms_tick) filt_reg <= filt_reg + filt_step;
            below_reg <= below_nxt;
        end
    end

    // ****************************************
    // safe direction monitor
    // ****************************************
    ssdm_dir_state_t    state_reg;
    ssdm_dir_state_t    state_next;
    logic [15:0]        dcnt_reg;
    logic [31:0]        angle_reg;
    logic               dir_pos_reg;

    wire        dir_sel   = select_positive || select_negative;
    wire        dir_on    = ext_en_reg && dir_en_reg && (motor_on || !dir_off_reg);
    wire [15:0] fwd_abs   = speed_rpm[15] ? 16'(-speed_rpm) : speed_rpm;
    wire        forbidden = dir_pos_reg ? speed_rpm[15] : (speed_rpm > 16'sh0000);
    wire [31:0] ang_step  = forbidden ? 32'(fwd_abs) * 32'(MDEG_PER_RPMMS) : 32'h00000000;
    wire [31:0] tol_mdeg  = 32'(tol_reg) * 32'(MDEG_PER_DEG);
    wire        over_tol  = angle_reg > tol_mdeg;
    wire        dly_done  = ms_tick && (dcnt_reg + 16'h0001 >= delay_reg);
    wire        ramp_done = ms_tick && (dcnt_reg + 16'h0001 >= ramp_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DIR_IDLE:       if (dir_sel) state_next = DIR_DELAY;
            DIR_DELAY:      if (dly_done || delay_reg == 16'h0000) state_next = DIR_WATCH;
            DIR_WATCH:      if (over_tol) state_next = resp_reg ? DIR_BRAKE : DIR_TORQUE_OFF;
            DIR_BRAKE:      if (ramp_done || ramp_reg == 16'h0000) state_next = DIR_TORQUE_OFF;
            DIR_TORQUE_OFF: state_next = DIR_TORQUE_OFF;
        endcase
        if (!dir_sel || !dir_on) state_next = DIR_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg   <= DIR_IDLE;
            dcnt_reg    <= 16'h0000;
            angle_reg   <= 32'h00000000;
            dir_pos_reg <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
            if (state_next != state_reg) dcnt_reg <= 16'h0000;
            else if (ms_tick) dcnt_reg <= dcnt_reg + 16'h0001;
            if (state_reg == DIR_IDLE) begin
                angle_reg   <= 32'h00000000;
                dir_pos_reg <= select_positive;
            end else if (state_reg == DIR_WATCH && ms_tick) begin
                angle_reg <= angle_reg + ang_step;
            end
        end
    end

    // ****************************************
    // direction outputs
    // ****************************************
    wire watch_nxt = (state_next == DIR_WATCH) || (state_next == DIR_BRAKE) || (state_next == DIR_TORQUE_OFF);
    wire viol_set  = (state_reg == DIR_WATCH) && over_tol && (state_next != DIR_IDLE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pos_reg   <= 1'b0;
            neg_reg   <= 1'b0;
            viol_reg  <= 1'b0;
            fstop_reg <= 1'b0;
            toff_reg  <= 1'b0;
            slim_reg  <= 1'b0;
        end else if (ce) begin
            pos_reg   <= watch_nxt && dir_pos_reg;
            neg_reg   <= watch_nxt && !dir_pos_reg;
            // a violation in the same cycle as deselection does not latch
            viol_reg  <= viol_set || (viol_reg && state_next != DIR_IDLE);
            fstop_reg <= (state_next == DIR_DELAY) || (state_next == DIR_BRAKE);
            toff_reg  <= (state_next == DIR_TORQUE_OFF);
            slim_reg  <= (state_next != DIR_IDLE) && !(acc_act_reg || accept_go);
        end
    end

    assign prdata                         = prdata_reg;
    assign pready                         = pready_reg;
    assign pslverr                        = pslverr_reg;
    assign below_speed_limit_flag         = below_reg;
    assign positive_direction_active_flag = pos_reg;
    assign negative_direction_active_flag = neg_reg;
    assign direction_violation            = viol_reg;
    assign fast_stop_ramp                 = fstop_reg;
    assign torque_off                     = toff_reg;
    assign speed_limit_active             = slim_reg;
    assign acceptance_active              = acc_act_reg;
    assign fast_stop_ramp_time            = ramp_reg;

    // ****************************************
    // checks
    // ****************************************
    sequence s_enter_delay;
        ce && state_reg == DIR_IDLE && state_next == DIR_DELAY;
    endsequence

    sequence s_violate(logic r);
        ce && state_reg == DIR_WATCH && over_tol && dir_sel && dir_on && resp_reg == r;
    endsequence

    chk_accept_clamp: assert property (@(posedge clk_sys) disable iff (rst)
        accept_time_reg <= ACCEPT_MAX) else $error("acceptance time above limit");

    chk_accept_unlimits: assert property (@(posedge clk_sys) disable iff (rst)
        acc_act_reg && ce |=> !slim_reg) else $error("speed limited during acceptance");

    chk_speed_off: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !ssm_on |=> !below_reg) else $error("below flag while monitor off");

    chk_below_plain: assert property (@(posedge clk_sys) disable iff (rst)
        ce && ssm_on && !hyst_en_reg && spd_abs < limit_reg |=> below_reg)
        else $error("below flag missed");

    chk_delay_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        s_enter_delay |=> !pos_reg && !neg_reg && fstop_reg) else $error("direction active before delay");

    chk_stop_torque: assert property (@(posedge clk_sys) disable iff (rst)
        s_violate(1'b0) |=> toff_reg && viol_reg && !fstop_reg) else $error("immediate stop missing");

    chk_stop_brake: assert property (@(posedge clk_sys) disable iff (rst)
        s_violate(1'b1) |=> fstop_reg && viol_reg && !toff_reg) else $error("braking stop missing");

    chk_ext_gate: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !ext_en_reg |=> !pos_reg && !neg_reg && !below_reg) else $error("monitor active when inhibited");

    chk_apb_wait: assert property (@(posedge clk_sys) disable iff (rst)
        ce && psel && penable && !pready_reg |=> pready_reg) else $error("apb answer late");
endmodule

//--- ssdm_partner.sv
/*
 * motor model on the far side: speed feedback follows a target, brakes when told.
 * assumes target and run command change just after rising edges of clk_sys.
 */
`timescale 1ns/1ps
module ssdm_partner #(
    parameter int STEP = 4
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic signed [15:0] target_rpm,
    input  wire logic               run_cmd,
    input  wire logic               fast_stop_ramp,
    input  wire logic               torque_off,
    output logic signed [15:0]      speed_rpm,
    output logic                    motor_on
);
    // ****************************************
    // motor mechanics
    // ****************************************
    logic signed [15:0] aim;

    // no torque or a stop request pulls the load to standstill
    assign aim = (fast_stop_ramp || torque_off || !motor_on) ? 16'sh0000 : target_rpm;

    // STEP limits the slew, so a large STEP models a prompt drive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speed_rpm <= 16'sh0000;
            motor_on  <= 1'b0;
        end else begin
            motor_on <= run_cmd;
            if (aim > speed_rpm + STEP)
                speed_rpm <= speed_rpm + 16'(STEP);
            else if (aim < speed_rpm - STEP)
                speed_rpm <= speed_rpm - 16'(STEP);
            else
                speed_rpm <= aim;
        end
    end
endmodule

//--- ssdm_monitor_test.sv
/*
 * self-checking bench of ssdm_monitor with the motor model ssdm_partner.
 * assumes ssdm_pkg and both modules compiled first; one ms shortened to 10 cycles.
 */
`timescale 1ns/1ps
module ssdm_monitor_test;
    import ssdm_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int MS = 10;
    logic               clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr, re, prev;
    logic               run_cmd, sel_pos, sel_neg, motor_on, below_f, pos_f, neg_f, viol, fsr, toff, slim, acc;
    logic        [7:0]  paddr, st;
    logic        [31:0] pwdata, prdata, rv, lfsr;
    logic        [15:0] ramp_t;
    logic signed [15:0] speed_rpm, target_rpm;
    logic        [7:0]  ofs [10];
    logic        [31:0] rst_val [10];
    int                 failures, cmp_count;

    assign st = {slim, toff, fsr, acc, viol, neg_f, pos_f, below_f};

    ssdm_monitor #(.MS_CYCLES(MS)) i_ssdm_monitor (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .speed_rpm(speed_rpm), .motor_on(motor_on), .select_positive(sel_pos),
        .select_negative(sel_neg), .below_speed_limit_flag(below_f), .positive_direction_active_flag(pos_f),
        .negative_direction_active_flag(neg_f), .direction_violation(viol), .fast_stop_ramp(fsr),
        .torque_off(toff), .speed_limit_active(slim), .acceptance_active(acc), .fast_stop_ramp_time(ramp_t));

    ssdm_partner #(.STEP(64)) i_ssdm_partner (.clk_sys(clk_sys), .rst(rst), .target_rpm(target_rpm),
        .run_cmd(run_cmd), .fast_stop_ramp(fsr), .torque_off(toff), .speed_rpm(speed_rpm), .motor_on(motor_on));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic exp_below(input int s, input logic p, input logic h);
        int a;
        a = (s < 0) ? -s : s;
        if (!h)
            return a < int'(LIMIT_RST);
        if (a >= int'(LIMIT_RST))
            return 1'b0;
        return (a < int'(LIMIT_RST) - int'(HYST_RST)) ? 1'b1 : p;
    endfunction

    // one transfer; the request stands until pready is seen high or 20 cycles pass
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        re = pslverr;
        if (n >= 20)
            failures++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_for(input int i, input logic lv, input int lim);
        int n;
        n = 0;
        while (st[i] !== lv && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(st[i]), 32'(lv));
    endtask

    task automatic step_speed(input int s, input logic h);
        target_rpm <= 16'(s);
        repeat (4) @(posedge clk_sys);
        prev = exp_below(s, prev, h);
        check(32'(below_f), 32'(prev));
    endtask

    task automatic sweep(input logic h);
        int c [8];
        c = '{25, 15, 5, 15, 19, 20, -9, -10};
        foreach (c[i])
            step_speed(c[i], h);
        repeat (30) begin
            lfsr = lfsr_next(lfsr);
            // span kept under one model step, so no midway speed trips the band
            step_speed(int'(lfsr[5:0]) - 32, h);
        end
    endtask

    // ****************************************
    // clock, watchdog and sequence
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        failures++;
        report_and_stop;
    end

    initial begin
        {rst, ce} = 2'b11;
        {psel, penable, pwrite, run_cmd, sel_pos, sel_neg, prev} = 7'h00;
        {paddr, pwdata, target_rpm} = '0;
        lfsr = 32'hBAB69846;
        failures = 0;
        cmp_count = 0;
        ofs = '{OFS_CTRL, OFS_LIMIT, OFS_HYST, OFS_FILT, OFS_ACCEPT, OFS_DELAY, OFS_TOL, OFS_RAMP, OFS_STATUS, 8'h24};
        rst_val = '{32'(RESP_RST) << 5, 32'(LIMIT_RST), 32'(HYST_RST), 32'(FILT_RST), 32'(ACCEPT_RST),
                    32'(DELAY_RST), 32'(TOL_RST), 32'(RAMP_RST), 32'h0, 32'h0};
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(32'(ramp_t), 32'(RAMP_RST));
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            check(rv, rst_val[i]);
            check(32'(re), 32'(i == 9));
        end
        foreach (rst_val[i]) begin
            lfsr = lfsr_next(lfsr);
            rv = (i < 2) ? 32'(ACCEPT_MAX) + 32'(i) : 32'(lfsr[17:0]);
            apb(1'b1, OFS_ACCEPT, rv);
            apb(1'b0, OFS_ACCEPT, 32'h0);
            check(rv, (32'(lfsr[17:0]) > 32'(ACCEPT_MAX) || i < 2) ? 32'(ACCEPT_MAX) : 32'(lfsr[17:0]));
        end
        run_cmd <= 1'b1;
        target_rpm <= 16'sd5;
        repeat (4) @(posedge clk_sys);
        check(32'(below_f), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h29);
        run_cmd <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(32'(below_f), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h21);
        repeat (3) @(posedge clk_sys);
        check(32'(below_f), 32'h1);
        run_cmd <= 1'b1;
        sweep(1'b0);
        apb(1'b1, OFS_CTRL, 32'h23);
        sweep(1'b1);
        apb(1'b1, OFS_FILT, 32'h1);
        target_rpm <= 16'sd30;
        repeat (20 * MS) @(posedge clk_sys);
        target_rpm <= 16'sd0;
        repeat (3) @(posedge clk_sys);
        check(32'(below_f), 32'h0);
        wait_for(0, 1'b1, 20 * MS);
        apb(1'b1, OFS_FILT, 32'h0);
        apb(1'b1, OFS_DELAY, 32'h2);
        apb(1'b1, OFS_TOL, 32'h1);
        apb(1'b1, OFS_RAMP, 32'h2);
        apb(1'b1, OFS_ACCEPT, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h21);
        sel_pos <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(32'(st[7:1]), 32'h0);
        // direction is latched on entry, so no select may stand while enabling
        sel_pos <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, OFS_CTRL, 32'h05 | (32'(r) << 5));
            sel_pos <= r[0];
            sel_neg <= ~r[0];
            repeat (2) @(posedge clk_sys);
            check(32'({st[7:5], st[2:1]}), 32'h14);
            wait_for(r ? 1 : 2, 1'b1, 4 * MS);
            check(32'(st[2:1]), r ? 32'h1 : 32'h2);
            if (r) begin
                apb(1'b1, OFS_CTRL, 32'h65);
                check(32'({st[7], st[4]}), 32'h1);
                wait_for(4, 1'b0, 5 * MS);
                repeat (2) @(posedge clk_sys);
                check(32'(st[7]), 32'h1);
            end
            target_rpm <= r ? -16'sd20 : 16'sd20;
            repeat (5 * MS) @(posedge clk_sys);
            check(32'(st[3]), 32'h0);
            wait_for(3, 1'b1, 12 * MS);
            @(posedge clk_sys);
            if (r) begin
                check(32'(st[6:5]), 32'h1);
                wait_for(6, 1'b1, 4 * MS);
                check(32'(st[5]), 32'h0);
            end else begin
                check(32'(st[6]), 32'h1);
            end
            sel_pos <= 1'b0;
            sel_neg <= 1'b0;
            target_rpm <= 16'sd0;
            repeat (3) @(posedge clk_sys);
            check(32'(st[7:1]), 32'h0);
        end
        apb(1'b1, OFS_CTRL, 32'h15);
        sel_pos <= 1'b1;
        wait_for(1, 1'b1, 4 * MS);
        run_cmd <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(32'(st[2:1]), 32'h0);
        sel_pos <= 1'b0;
        report_and_stop;
    end
endmodule
